// file: hw/tal_pkg.sv
// Purpose: constants shared by the alarm-limit register block
// Assumes: 16-bit register words reached through an 8-bit pointer
// Notes: limit words use bits 12:2, temperature word bits 12:1

package tal_pkg;

   localparam logic [7:0]  TAL_PTR_CONFIG   = 8'h01;
   localparam logic [7:0]  TAL_PTR_LOWER    = 8'h03;
   localparam logic [7:0]  TAL_PTR_CRIT     = 8'h04;
   localparam logic [7:0]  TAL_PTR_TEMP     = 8'h05;

   localparam logic [15:0] TAL_LIMIT_MASK   = 16'h1FFC;
   localparam logic [15:0] TAL_REG_RESET    = 16'h0000;
   localparam logic [11:0] TAL_TEMP_RESET   = 12'h000;

   localparam int          TAL_BIT_CRIT_LOCK = 7;
   localparam int          TAL_BIT_WIN_LOCK  = 6;
   localparam int          TAL_BIT_ALARM_EN  = 3;

   localparam int          TAL_BIT_OVER_CRIT = 15;
   localparam int          TAL_BIT_ABOVE     = 14;
   localparam int          TAL_BIT_BELOW     = 13;

   localparam int          TAL_LIM_MSB       = 12;
   localparam int          TAL_LIM_LSB       = 2;
   localparam int          TAL_CMP_W         = 13;
   localparam int          TAL_TEMP_W        = 12;
   localparam int          TAL_HYST_W        = 11;

   typedef logic signed [TAL_CMP_W-1:0] tal_cmp_t;

endpackage : tal_pkg

// file: hw/tal_sync.sv
// Purpose: two-flop synchroniser for one level or toggle
// Assumes: d changes no faster than the destination clock can see
// Notes: only the second flop is visible outside

`timescale 1ns/1ps
`default_nettype none

module tal_sync (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic d,
   output logic      q
);

   logic meta_q;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         meta_q <= 1'b0;
         q      <= 1'b0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule : tal_sync

`default_nettype wire

// file: hw/tal_limit_regs.sv
// Purpose: lower/critical limit and temperature result registers
// Assumes: link side is the two-wire engine's parallel port on link_clk
// Notes: registers and comparators live on sys_clk; a toggle handshake
//   carries each pointer access across, held words stay stable meanwhile

`timescale 1ns/1ps
`default_nettype none

module tal_limit_regs
   import tal_pkg::*;
(
   input  wire logic                  sys_clk,
   input  wire logic                  resetn,
   input  wire logic                  conv_valid,
   input  wire logic [TAL_TEMP_W-1:0] conv_temp,
   input  wire logic [15:0]           upper_limit,
   input  wire logic [TAL_HYST_W-1:0] hyst_qdeg,
   input  wire logic                  link_clk,
   input  wire logic                  link_resetn,
   input  wire logic                  link_req,
   input  wire logic                  link_write,
   input  wire logic [7:0]            link_ptr,
   input  wire logic [15:0]           link_wdata,
   output logic                       link_busy,
   output logic                       link_done,
   output logic [15:0]                link_rdata,
   output logic                       window_limit_lock,
   output logic                       critical_limit_lock,
   output logic                       alarm_output_enable,
   output logic                       alarm_out,
   output logic                       alarm_oe
);

   function automatic tal_cmp_t tal_field(input logic [15:0] r);
      return tal_cmp_t'($signed(r[TAL_LIM_MSB:TAL_LIM_LSB]));
   endfunction : tal_field

   function automatic tal_cmp_t tal_less_hyst(input tal_cmp_t lim,
                                              input logic [TAL_HYST_W-1:0] h);
      return lim - tal_cmp_t'({1'b0, h});
   endfunction : tal_less_hyst

   // ---------------- link domain ----------------
   logic        lk_busy_q;
   logic        lk_req_tgl_q;
   logic        lk_write_q;
   logic [7:0]  lk_ptr_q;
   logic [15:0] lk_wdata_q;
   logic        lk_ack_s;
   logic        lk_ack_prev_q;
   logic        lk_done_q;
   logic [15:0] lk_rdata_q;
   logic        lk_ack_seen;

   // ---------------- sys domain -----------------
   logic        req_s;
   logic        req_prev_q;
   logic        ack_tgl_q;
   logic [15:0] rdata_q;
   logic [15:0] lower_q;
   logic [15:0] crit_q;
   logic [TAL_TEMP_W-1:0] temp_val_q;
   logic        win_lock_q;
   logic        crit_lock_q;
   logic        alarm_en_q;
   logic        over_crit_q;
   logic        above_q;
   logic        below_q;
   logic        alarm_q;
   logic        go;
   logic        wr_go;
   logic [15:0] temp_word;
   tal_cmp_t    t_new;
   tal_cmp_t    lim_lo;
   tal_cmp_t    lim_cr;
   tal_cmp_t    lim_up;

   assign lk_ack_seen = lk_ack_s ^ lk_ack_prev_q;
   assign link_busy   = lk_busy_q;
   assign link_done   = lk_done_q;
   assign link_rdata  = lk_rdata_q;

   // held words stay put while busy, so the sys side may sample them
   always_ff @(posedge link_clk) begin
      if (!link_resetn) begin
         lk_busy_q    <= 1'b0;
         lk_req_tgl_q <= 1'b0;
         lk_write_q   <= 1'b0;
         lk_ptr_q     <= 8'h00;
         lk_wdata_q   <= TAL_REG_RESET;
      end else if (link_req && !lk_busy_q) begin
         lk_busy_q    <= 1'b1;
         lk_req_tgl_q <= ~lk_req_tgl_q;
         lk_write_q   <= link_write;
         lk_ptr_q     <= link_ptr;
         lk_wdata_q   <= link_wdata;
      end else if (lk_ack_seen) begin
         lk_busy_q    <= 1'b0;
      end
   end

   tal_sync u_ack_sync (
      .clk    (link_clk),
      .resetn (link_resetn),
      .d      (ack_tgl_q),
      .q      (lk_ack_s)
   );

   always_ff @(posedge link_clk) begin
      if (!link_resetn) begin
         lk_ack_prev_q <= 1'b0;
         lk_done_q     <= 1'b0;
         lk_rdata_q    <= TAL_REG_RESET;
      end else begin
         lk_ack_prev_q <= lk_ack_s;
         lk_done_q     <= lk_ack_seen;
         if (lk_ack_seen) begin
            lk_rdata_q <= rdata_q;
         end
      end
   end

   tal_sync u_req_sync (
      .clk    (sys_clk),
      .resetn (resetn),
      .d      (lk_req_tgl_q),
      .q      (req_s)
   );

   assign go    = req_s ^ req_prev_q;
   assign wr_go = go && lk_write_q;

   // bits 15:13 are trip flags, 12 sign, 11:1 magnitude, 0 reads zero
   assign temp_word = {over_crit_q, above_q, below_q,
                       temp_val_q, 1'b0};

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         req_prev_q <= 1'b0;
         ack_tgl_q  <= 1'b0;
         rdata_q    <= TAL_REG_RESET;
      end else begin
         req_prev_q <= req_s;
         if (go) begin
            ack_tgl_q <= ~ack_tgl_q;
            case (lk_ptr_q)
               TAL_PTR_CONFIG: begin
                  rdata_q <= TAL_REG_RESET;
                  rdata_q[TAL_BIT_CRIT_LOCK] <= crit_lock_q;
                  rdata_q[TAL_BIT_WIN_LOCK]  <= win_lock_q;
                  rdata_q[TAL_BIT_ALARM_EN]  <= alarm_en_q;
               end
               TAL_PTR_LOWER: rdata_q <= lower_q;
               TAL_PTR_CRIT:  rdata_q <= crit_q;
               TAL_PTR_TEMP:  rdata_q <= temp_word;
               default:       rdata_q <= TAL_REG_RESET;
            endcase
         end
      end
   end

   // locks only ever set; clearing needs a power-on reset
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         win_lock_q  <= 1'b0;
         crit_lock_q <= 1'b0;
         alarm_en_q  <= 1'b0;
      end else if (wr_go && lk_ptr_q == TAL_PTR_CONFIG) begin
         win_lock_q  <= win_lock_q | lk_wdata_q[TAL_BIT_WIN_LOCK];
         crit_lock_q <= crit_lock_q | lk_wdata_q[TAL_BIT_CRIT_LOCK];
         if (!win_lock_q && !crit_lock_q) begin
            alarm_en_q <= lk_wdata_q[TAL_BIT_ALARM_EN];
         end
      end
   end

   // reserved bits are masked off on the way in, so they read zero
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         lower_q <= TAL_REG_RESET;
      end else if (wr_go && lk_ptr_q == TAL_PTR_LOWER
                   && !win_lock_q) begin
         lower_q <= lk_wdata_q & TAL_LIMIT_MASK;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         crit_q <= TAL_REG_RESET;
      end else if (wr_go && lk_ptr_q == TAL_PTR_CRIT
                   && !crit_lock_q) begin
         crit_q <= lk_wdata_q & TAL_LIMIT_MASK;
      end
   end

   // the temperature word has no write path at all
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         temp_val_q <= TAL_TEMP_RESET;
      end else if (conv_valid) begin
         temp_val_q <= conv_temp;
      end
   end

   // compare on bits 12:2 only; the eighth-degree bit has no limit peer
   assign t_new  = tal_cmp_t'($signed(conv_temp[TAL_TEMP_W-1:1]));
   assign lim_lo = tal_field(lower_q);
   assign lim_cr = tal_field(crit_q);
   assign lim_up = tal_field(upper_limit);

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         over_crit_q <= 1'b0;
         above_q     <= 1'b0;
         below_q     <= 1'b0;
      end else if (conv_valid) begin
         if (t_new >= lim_cr) begin
            over_crit_q <= 1'b1;
         end else if (t_new <= tal_less_hyst(lim_cr, hyst_qdeg)) begin
            over_crit_q <= 1'b0;
         end
         if (t_new > lim_up) begin
            above_q <= 1'b1;
         end else if (t_new <= tal_less_hyst(lim_up, hyst_qdeg)) begin
            above_q <= 1'b0;
         end
         below_q <= (t_new < lim_lo);
      end
   end

   // comparator-style alarm, open-drain active low on the pin
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         alarm_q <= 1'b0;
      end else begin
         alarm_q <= alarm_en_q
                    && (over_crit_q || above_q || below_q);
      end
   end

   assign alarm_out           = 1'b0;
   assign alarm_oe            = alarm_q;
   assign window_limit_lock   = win_lock_q;
   assign critical_limit_lock = crit_lock_q;
   assign alarm_output_enable = alarm_en_q;

   a_lower_lock_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
      win_lock_q |=> $stable(lower_q))
      else $error("lower limit changed while window lock set");

   a_crit_lock_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
      crit_lock_q |=> $stable(crit_q))
      else $error("critical limit changed while locked");

   a_lock_sticky: assert property (@(posedge sys_clk) disable iff (!resetn)
      (win_lock_q |=> win_lock_q) and (crit_lock_q |=> crit_lock_q))
      else $error("lock bit cleared without reset");

   a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
      ((lower_q | crit_q) & ~TAL_LIMIT_MASK) == 16'h0000)
      else $error("reserved limit bit is set");

   a_lower_write: assert property (@(posedge sys_clk) disable iff (!resetn)
      (wr_go && lk_ptr_q == TAL_PTR_LOWER && !win_lock_q)
      |=> lower_q == ($past(lk_wdata_q) & TAL_LIMIT_MASK))
      else $error("unlocked lower limit write not stored");

   a_temp_load: assert property (@(posedge sys_clk) disable iff (!resetn)
      conv_valid |=> temp_val_q == $past(conv_temp) && temp_word[0] == 1'b0)
      else $error("conversion result not loaded");

   a_crit_flag_set: assert property (@(posedge sys_clk) disable iff (!resetn)
      (conv_valid && t_new >= lim_cr) |=> over_crit_q)
      else $error("over-critical flag missed");

   a_below_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
      conv_valid |=> below_q == ($past(t_new) < $past(lim_lo)))
      else $error("below-window flag wrong");

   a_alarm_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
      !alarm_en_q ##1 !alarm_en_q |-> !alarm_oe)
      else $error("alarm driven while disabled");

   a_alarm_crit: assert property (@(posedge sys_clk) disable iff (!resetn)
      (alarm_en_q && over_crit_q) |=> alarm_oe)
      else $error("alarm not driven over critical");

   a_link_done: assert property (@(posedge link_clk) disable iff (!link_resetn)
      lk_done_q |-> !lk_busy_q)
      else $error("done pulse while still busy");

   c_locked_write: cover property (@(posedge sys_clk) disable iff (!resetn)
      wr_go && lk_ptr_q == TAL_PTR_LOWER && win_lock_q);
   c_crit_trip: cover property (@(posedge sys_clk) disable iff (!resetn)
      $rose(over_crit_q));
   c_alarm_on: cover property (@(posedge sys_clk) disable iff (!resetn)
      $rose(alarm_oe));
   c_link_read: cover property (@(posedge link_clk) disable iff (!link_resetn)
      lk_done_q && !lk_write_q && lk_ptr_q == TAL_PTR_TEMP);

endmodule : tal_limit_regs

`default_nettype wire

// file: dv/tal_link_host.sv
// Purpose: link-side host model issuing whole register word accesses
// Assumes: one access at a time, request pulse taken while busy is low
// Notes: released fields show the inverse of their last value

`timescale 1ns/1ps
`default_nettype none

module tal_link_host (
   input  wire logic        link_clk,
   input  wire logic        link_busy,
   input  wire logic        link_done,
   input  wire logic [15:0] link_rdata,
   output logic             link_req,
   output logic             link_write,
   output logic [7:0]       link_ptr,
   output logic [15:0]      link_wdata
);

   initial begin
      link_req   = 1'b0;
      link_write = 1'b0;
      link_ptr   = 8'h00;
      link_wdata = 16'h0000;
   end

   // a lost answer leaves rd unknown so the caller's compare fails
   task automatic access(input logic wr, input logic [7:0] ptr,
                         input logic [15:0] wd, output logic [15:0] rd);
      int n;
      rd = 'x;
      // fields move on falling edges, clear of the design's sampling edge
      @(negedge link_clk);
      link_req   = 1'b1;
      link_write = wr;
      link_ptr   = ptr;
      link_wdata = wd;
      @(posedge link_clk);
      @(negedge link_clk);
      link_req = 1'b0;
      for (n = 0; n < 20; n++) begin
         @(posedge link_clk);
         if (link_done === 1'b1) begin
            rd = link_rdata;
            break;
         end
      end
      @(negedge link_clk);
      link_write = ~wr;
      link_ptr   = ~ptr;
      link_wdata = ~wd;
   endtask : access

endmodule : tal_link_host

`default_nettype wire

// file: dv/temp_alarm_limit_registers_tb_top.sv
// Purpose: self-checking bench for the alarm-limit register block
// Assumes: conversions driven on sys_clk falling edges
// Notes: limits 10, 80 and 60 degC, hysteresis 2 degC

`timescale 1ns/1ps
`default_nettype none

module temp_alarm_limit_registers_tb_top;
   import tal_pkg::*;

   logic                  sys_clk;
   logic                  resetn;
   logic                  link_clk;
   logic                  link_resetn;
   logic                  conv_valid;
   logic [TAL_TEMP_W-1:0] conv_temp;
   logic [15:0]           upper_limit;
   logic [TAL_HYST_W-1:0] hyst_qdeg;
   logic                  link_req;
   logic                  link_write;
   logic [7:0]            link_ptr;
   logic [15:0]           link_wdata;
   logic                  link_busy;
   logic                  link_done;
   logic [15:0]           link_rdata;
   logic                  window_limit_lock;
   logic                  critical_limit_lock;
   logic                  alarm_output_enable;
   logic                  alarm_out;
   logic                  alarm_oe;
   logic [15:0]           dmy;
   int                    error_cnt;
   int                    num_checks;

   tal_limit_regs tal_limit_regs_inst (.sys_clk(sys_clk), .resetn(resetn),
      .conv_valid(conv_valid), .conv_temp(conv_temp),
      .upper_limit(upper_limit), .hyst_qdeg(hyst_qdeg),
      .link_clk(link_clk), .link_resetn(link_resetn), .link_req(link_req),
      .link_write(link_write), .link_ptr(link_ptr), .link_wdata(link_wdata),
      .link_busy(link_busy), .link_done(link_done), .link_rdata(link_rdata),
      .window_limit_lock(window_limit_lock),
      .critical_limit_lock(critical_limit_lock),
      .alarm_output_enable(alarm_output_enable), .alarm_out(alarm_out),
      .alarm_oe(alarm_oe));

   tal_link_host tal_link_host_inst (.link_clk(link_clk),
      .link_busy(link_busy), .link_done(link_done), .link_rdata(link_rdata),
      .link_req(link_req), .link_write(link_write), .link_ptr(link_ptr),
      .link_wdata(link_wdata));

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // odd start offset keeps the link clock out of phase with sys_clk
   initial begin
      link_clk = 1'b0;
      #37;
      forever #80 link_clk = ~link_clk;
   end

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input string what, input logic [15:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [7:0] p, input logic [15:0] d);
      tal_link_host_inst.access(1'b1, p, d, dmy);
   endtask : wr

   task automatic rchk(input string what, input logic [7:0] p,
                       input logic [15:0] exp);
      logic [15:0] v;
      tal_link_host_inst.access(1'b0, p, 16'h0000, v);
      chk(what, v, exp);
      chk("busy idle", {15'h0000, link_busy}, 16'h0000);
   endtask : rchk

   task automatic conv(input logic [TAL_TEMP_W-1:0] t);
      @(negedge sys_clk);
      conv_valid = 1'b1;
      conv_temp  = t;
      @(negedge sys_clk);
      conv_valid = 1'b0;
      repeat (3) @(negedge sys_clk);
   endtask : conv

   task automatic t_reset;
      rchk("config", 8'h01, 16'h0000);
      rchk("lower", 8'h03, 16'h0000);
      rchk("crit", 8'h04, 16'h0000);
      rchk("temp", 8'h05, 16'h0000);
      rchk("unmapped", 8'h06, 16'h0000);
      chk("alarm_out", {15'h0000, alarm_out}, 16'h0000);
   endtask : t_reset

   task automatic t_limits;
      wr(8'h03, 16'hFFFF);
      rchk("lower", 8'h03, 16'h1FFC);
      wr(8'h04, 16'hF503);
      rchk("crit", 8'h04, 16'h1500);
      wr(8'h05, 16'h1234);
      rchk("temp ro", 8'h05, 16'h0000);
      wr(8'h03, 16'h00A0);
      wr(8'h04, 16'h0500);
   endtask : t_limits

   // temperatures in eighth degrees, flags crit/above/below expected
   task automatic t_flags;
      logic [11:0] tt [8];
      logic [2:0]  fl [8];
      tt = '{12'h028, 12'h028, 12'h050, 12'hFF8,
             12'h280, 12'h278, 12'h270, 12'h1D0};
      fl = '{3'h1, 3'h1, 3'h0, 3'h1, 3'h6, 3'h6, 3'h2, 3'h0};
      for (int i = 0; i < 8; i++) begin
         if (i == 1) wr(8'h01, 16'h0008);
         conv(tt[i]);
         rchk("temp", 8'h05, {fl[i], tt[i], 1'b0});
         chk("alarm", {15'h0000, alarm_oe}, {15'h0000, (i > 0) & |fl[i]});
      end
   endtask : t_flags

   task automatic t_locks;
      wr(8'h01, 16'h0048);
      wr(8'h03, 16'h0050);
      rchk("lower locked", 8'h03, 16'h00A0);
      wr(8'h04, 16'h0480);
      rchk("crit open", 8'h04, 16'h0480);
      wr(8'h01, 16'h0080);
      wr(8'h04, 16'h0500);
      rchk("crit locked", 8'h04, 16'h0480);
      wr(8'h01, 16'h0000);
      rchk("config", 8'h01, 16'h00C8);
      chk("locks", {14'h0000, critical_limit_lock, window_limit_lock}, 16'h0003);
      chk("alarm en", {15'h0000, alarm_output_enable}, 16'h0001);
   endtask : t_locks

   initial begin
      #500000;
      error_cnt++;
      wrap_up();
   end

   initial begin
      error_cnt   = 0;
      num_checks  = 0;
      resetn      = 1'b0;
      link_resetn = 1'b0;
      conv_valid  = 1'b0;
      conv_temp   = 12'h000;
      upper_limit = 16'h03C0;
      hyst_qdeg   = 11'h008;
      repeat (20) @(negedge sys_clk);
      resetn      = 1'b1;
      link_resetn = 1'b1;
      t_reset();
      t_limits();
      t_flags();
      t_locks();
      wrap_up();
   end

endmodule : temp_alarm_limit_registers_tb_top

`default_nettype wire
